// ### shared/pls_defs.svh
// Constants for the PIPE link status and control block.
// Assumes inclusion by pls_pkg, the design module, the checker and the bench.
`ifndef PLS_DEFS_SVH
`define PLS_DEFS_SVH
`define PLS_ADDR_CTRL 8'h00
`define PLS_ADDR_MARGIN 8'h04
`define PLS_ADDR_STATUS 8'h08
`define PLS_ADDR_CAPS 8'h0C
`define PLS_CTRL_RESET 8'h0E
`define PLS_CTRL_LINK_EN 0
`define PLS_CTRL_PCS_HOLD 1
`define PLS_CTRL_UPCFG_CAP 2
`define PLS_CTRL_FAST_CAP 3
`define PLS_CTRL_FACES_UP 4
`define PLS_CTRL_SEL_DEEMPH 5
`define PLS_CTRL_TX_L0S 6
`define PLS_CODE_DET_QUIET 6'h00
`define PLS_CODE_DET_ACTIVE 6'h02
`define PLS_CODE_POL_ACTIVE 6'h04
`define PLS_CODE_CFG_LWIDTH 6'h0B
`define PLS_CODE_CFG_COMPLETE 6'h11
`define PLS_CODE_CFG_IDLE 6'h15
`define PLS_CODE_L0 6'h16
`define PLS_CODE_REC_LOCK 6'h1C
`define PLS_CODE_REC_CFG 6'h1D
`define PLS_CODE_REC_SPEED 6'h1E
`define PLS_CODE_REC_IDLE 6'h20
`define PLS_RX_DETECTED 3'h3
`define PLS_PWR_P0 2'h0
`define PLS_PWR_P0S 2'h1
`define PLS_PWR_P1 2'h2
`define PLS_WIDTH_UNTRAINED 3'h0
`define PLS_DEEMPH_6DB 1'h0
`define PLS_DEEMPH_3P5DB 1'h1
`define PLS_RATE_2G5 1'h0
`define PLS_RATE_5G0 1'h1
`define PLS_DET_WAIT 16'h0400
`endif

// ### shared/pls_pkg.sv
// Types for the PIPE link status and control block.
// Assumes pls_defs.svh sits beside it on the include path.
`include "pls_defs.svh"
package pls_pkg;
    typedef enum logic [3:0] {
        DET_QUIET, DET_ACTIVE, POL_ACTIVE, CFG_LWIDTH, CFG_COMPLETE,
        CFG_IDLE, LINK_L0, REC_LOCK, REC_CFG, REC_SPEED, REC_IDLE
    } pls_state_t;
    typedef enum logic [2:0] {
        TXS_NOT = 3'h0, TXS_ENTRY = 3'h1, TXS_IDLE = 3'h2, TXS_FTS = 3'h3
    } pls_txsub_t;
    typedef enum logic [1:0] {
        RXS_NOT = 2'h0, RXS_ENTRY = 2'h1, RXS_IDLE = 2'h2, RXS_FTS = 2'h3
    } pls_rxsub_t;
endpackage : pls_pkg

// ### src/pls_link_ctrl.sv
// Physical-layer status and control port toward a serial transceiver.
// Assumes a free 250 MHz core clock that samples the slower pipe clock
// pin; all pipe-side inputs are stable around the pipe clock rising edge.
// Functional notes
// - Current rate on one bit from its own flop, 0 is 2.5G, 1 is 5G.
// - Current width on two bits, 00 x1 up to 11 x8.
// - Six-bit training state code; codes 110100 and above never appear.
// - Lane reversal mode on two bits: none, 1:0, 3:0, 7:0.
// - Active-low link-up output, low while physical layer is up.
// - Target width is used only when request bit 0 is set.
// - Target speed is used only when request bit 1 is set.
// - Transmit low-power substate on three bits, 100 and up unused.
// - Receive low-power substate on two bits.
// - Upconfigure flag high only when both ends are upconfigure capable.
// - Fast-rate flag high when both ends support 5G at last L0 entry.
// - Partner fast flag high once partner advertised 5G into L0.
// - First trained width captured at first configuration idle.
// - Downstream at 5G, source bit picks partner or register value.
// - Detect control starts detection in P1 or loopback in P0.
// - Transceiver reset output holds the coding sublayer in reset.
// - Rate control to transceiver, 0 for 2.5G, 1 for 5G.
// - De-emphasis control, 0 for -6dB, 1 for -3.5dB.
// - Swing margin on three bits, 000 normal operation.
// - Per-lane power state: 00 P0, 01 P0s, 10 P1.
//
// Decided for this implementation: the placing of the registers and the plain strobed port.
`timescale 1ns/1ns
`include "pls_defs.svh"
module pls_link_ctrl
    import pls_pkg::*;
#(
    parameter int LANES = 8,
    parameter logic [15:0] DET_WAIT = `PLS_DET_WAIT
) (
    input wire logic core_clk,
    input wire logic resetn,
    input wire logic [7:0] regAddr,
    input wire logic [31:0] regWrData,
    input wire logic regWrStb,
    input wire logic regRdStb,
    output logic [31:0] regRdData,
    input wire logic phySideClock,
    input wire logic [1:0] forcedChangeReq,
    input wire logic [1:0] forcedTargetWidth,
    input wire logic forcedTargetSpeed,
    input wire logic forcedChangeAutonomous,
    input wire logic preferredDeemphasisIn,
    input wire logic deemphasisSourceSel,
    input wire logic [2:0] laneRxStatusCode,
    input wire logic partnerTrainingSeen,
    input wire logic [1:0] partnerWidth,
    input wire logic partnerLaneFlip,
    input wire logic partnerUpconfigBit,
    input wire logic partnerFastRate,
    input wire logic partnerDeemphasis,
    input wire logic partnerElecIdle,
    output logic currentRateSel,
    output logic [1:0] currentWidthSel,
    output logic [5:0] trainingStateCode,
    output logic [1:0] laneOrderFlipMode,
    output logic phyUpLow_n,
    output logic [2:0] txLowpowerSubstate,
    output logic [1:0] rxLowpowerSubstate,
    output logic upconfigCapableFlag,
    output logic fastRateCapableFlag,
    output logic partnerFastRateFlag,
    output logic [2:0] firstTrainedWidth,
    output logic xcvrDetectOrLoop,
    output logic xcvrPcsReset,
    output logic xcvrRateCtrl,
    output logic xcvrDeemphasisCtrl,
    output logic [2:0] xcvrSwingMargin,
    output logic [2*LANES-1:0] lanePowerState
);

    function automatic logic [5:0] stateCode(input pls_state_t s);
        unique case (s)
            DET_QUIET: stateCode = `PLS_CODE_DET_QUIET;
            DET_ACTIVE: stateCode = `PLS_CODE_DET_ACTIVE;
            POL_ACTIVE: stateCode = `PLS_CODE_POL_ACTIVE;
            CFG_LWIDTH: stateCode = `PLS_CODE_CFG_LWIDTH;
            CFG_COMPLETE: stateCode = `PLS_CODE_CFG_COMPLETE;
            CFG_IDLE: stateCode = `PLS_CODE_CFG_IDLE;
            LINK_L0: stateCode = `PLS_CODE_L0;
            REC_LOCK: stateCode = `PLS_CODE_REC_LOCK;
            REC_CFG: stateCode = `PLS_CODE_REC_CFG;
            REC_SPEED: stateCode = `PLS_CODE_REC_SPEED;
            REC_IDLE: stateCode = `PLS_CODE_REC_IDLE;
            default: stateCode = `PLS_CODE_DET_QUIET;
        endcase
    endfunction : stateCode

    logic [7:0] ctrl_reg;
    logic [2:0] margin_reg;
    logic clkMeta_reg;
    logic clkSync2_reg;
    logic clkSync3_reg;
    logic clkLevel_reg;
    logic pipeEn_reg;
    pls_state_t state_reg;
    pls_state_t state_next;
    logic [15:0] detCount_reg;
    logic trainedOnce_reg;
    logic partnerUpcfg_reg;
    logic partnerFastLast_reg;
    logic autonomous_reg;
    logic widthChange;
    logic speedChange;
    logic linkEn;
    logic fastOk;

    assign linkEn = ctrl_reg[`PLS_CTRL_LINK_EN];
    assign fastOk = ctrl_reg[`PLS_CTRL_FAST_CAP] & partnerFastLast_reg;
    assign widthChange = forcedChangeReq[0] &&
        (forcedTargetWidth != currentWidthSel);
    assign speedChange = forcedChangeReq[1] &&
        (forcedTargetSpeed != currentRateSel) &&
        (!forcedTargetSpeed || fastOk);

    // Three-stage sampler of the pipe clock pin; an edge counts only once
    // stages two and three agree, which rejects a single metastable sample.
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            clkMeta_reg <= 1'b0;
            clkSync2_reg <= 1'b0;
            clkSync3_reg <= 1'b0;
            clkLevel_reg <= 1'b0;
            pipeEn_reg <= 1'b0;
        end else begin
            clkMeta_reg <= phySideClock;
            clkSync2_reg <= clkMeta_reg;
            clkSync3_reg <= clkSync2_reg;
            pipeEn_reg <= 1'b0;
            if (clkSync2_reg == clkSync3_reg &&
                    clkSync3_reg != clkLevel_reg) begin
                clkLevel_reg <= clkSync3_reg;
                pipeEn_reg <= clkSync3_reg;
            end
        end
    end

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            ctrl_reg <= `PLS_CTRL_RESET;
            margin_reg <= 3'h0;
        end else if (regWrStb) begin
            if (regAddr == `PLS_ADDR_CTRL) begin
                ctrl_reg <= regWrData[7:0];
            end
            if (regAddr == `PLS_ADDR_MARGIN) begin
                margin_reg <= regWrData[2:0];
            end
        end
    end

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            regRdData <= 32'h0;
        end else if (regRdStb) begin
            unique case (regAddr)
                `PLS_ADDR_CTRL: regRdData <= {24'h0, ctrl_reg};
                `PLS_ADDR_MARGIN: regRdData <= {29'h0, margin_reg};
                `PLS_ADDR_STATUS: regRdData <= {16'h0, ~phyUpLow_n,
                    currentRateSel, currentWidthSel, laneOrderFlipMode,
                    trainingStateCode, 4'h0};
                `PLS_ADDR_CAPS: regRdData <= {24'h0, autonomous_reg,
                    upconfigCapableFlag, fastRateCapableFlag,
                    partnerFastRateFlag, 1'b0, firstTrainedWidth};
                default: regRdData <= 32'h0;
            endcase
        end else begin
            regRdData <= 32'h0;
        end
    end

    always_comb begin
        state_next = state_reg;
        unique case (state_reg)
            DET_QUIET: if (linkEn) state_next = DET_ACTIVE;
            DET_ACTIVE: begin
                if (laneRxStatusCode == `PLS_RX_DETECTED) begin
                    state_next = POL_ACTIVE;
                end else if (detCount_reg == DET_WAIT) begin
                    state_next = DET_QUIET;
                end
            end
            POL_ACTIVE: if (partnerTrainingSeen) state_next = CFG_LWIDTH;
            CFG_LWIDTH: state_next = CFG_COMPLETE;
            CFG_COMPLETE: state_next = CFG_IDLE;
            CFG_IDLE: state_next = LINK_L0;
            LINK_L0: begin
                if (widthChange || speedChange) begin
                    state_next = REC_LOCK;
                end
            end
            REC_LOCK: state_next = REC_CFG;
            REC_CFG: state_next = speedChange ? REC_SPEED : REC_IDLE;
            REC_SPEED: state_next = REC_IDLE;
            REC_IDLE: state_next = LINK_L0;
        endcase
        if (!linkEn) begin
            state_next = DET_QUIET;
        end
    end

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            state_reg <= DET_QUIET;
            detCount_reg <= 16'h0;
            trainingStateCode <= `PLS_CODE_DET_QUIET;
        end else if (pipeEn_reg) begin
            state_reg <= state_next;
            trainingStateCode <= stateCode(state_next);
            if (state_reg == DET_ACTIVE && state_next == DET_ACTIVE) begin
                detCount_reg <= detCount_reg + 16'h1;
            end else begin
                detCount_reg <= 16'h0;
            end
        end
    end

    // Width follows training and forced changes, rate follows forced changes, lane order follows training only.
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            currentRateSel <= `PLS_RATE_2G5;
            xcvrRateCtrl <= `PLS_RATE_2G5;
            currentWidthSel <= 2'h0;
            laneOrderFlipMode <= 2'h0;
            autonomous_reg <= 1'b0;
        end else if (pipeEn_reg) begin
            if (state_next == DET_QUIET) begin
                currentRateSel <= `PLS_RATE_2G5;
                xcvrRateCtrl <= `PLS_RATE_2G5;
            end else if (state_reg == REC_SPEED) begin
                currentRateSel <= forcedTargetSpeed;
                xcvrRateCtrl <= forcedTargetSpeed;
            end
            if (state_reg == CFG_LWIDTH) begin
                currentWidthSel <= partnerWidth;
                laneOrderFlipMode <= partnerLaneFlip ?
                    partnerWidth : 2'h0;
            end else if (state_reg == REC_CFG && widthChange) begin
                currentWidthSel <= forcedTargetWidth;
            end
            if (state_reg == LINK_L0 && state_next == REC_LOCK) begin
                autonomous_reg <= forcedChangeAutonomous;
            end
        end
    end

    // Capability flags are judged on the step into L0 from recovery or
    // configuration, so the partner's later silence does not drop them.
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            partnerUpcfg_reg <= 1'b0;
            partnerFastLast_reg <= 1'b0;
            upconfigCapableFlag <= 1'b0;
            fastRateCapableFlag <= 1'b0;
            partnerFastRateFlag <= 1'b0;
            firstTrainedWidth <= `PLS_WIDTH_UNTRAINED;
            trainedOnce_reg <= 1'b0;
            phyUpLow_n <= 1'b1;
        end else if (pipeEn_reg) begin
            if (state_reg == CFG_COMPLETE) begin
                partnerUpcfg_reg <= partnerUpconfigBit;
            end
            if (state_reg == CFG_IDLE && !trainedOnce_reg) begin
                trainedOnce_reg <= 1'b1;
                firstTrainedWidth <=
                    {1'b0, currentWidthSel} + 3'h1;
            end
            if ((state_reg == CFG_IDLE || state_reg == REC_IDLE) &&
                    state_next == LINK_L0) begin
                partnerFastLast_reg <= partnerFastRate;
                fastRateCapableFlag <= partnerFastRate &
                    ctrl_reg[`PLS_CTRL_FAST_CAP];
                upconfigCapableFlag <= partnerUpcfg_reg &
                    ctrl_reg[`PLS_CTRL_UPCFG_CAP];
                if (partnerFastRate) begin
                    partnerFastRateFlag <= 1'b1;
                end
            end
            // A link that falls back to detect is no longer fast capable,
            // and the partner fast flag, once set at an L0 entry, is cleared only here.
            if (state_next == DET_QUIET) begin
                partnerFastRateFlag <= 1'b0;
                fastRateCapableFlag <= 1'b0;
            end
            phyUpLow_n <= !(state_next == LINK_L0 ||
                state_next == REC_LOCK || state_next == REC_CFG ||
                state_next == REC_SPEED ||
                state_next == REC_IDLE);
        end
    end

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            txLowpowerSubstate <= TXS_NOT;
            rxLowpowerSubstate <= RXS_NOT;
        end else if (pipeEn_reg) begin
            if (state_reg != LINK_L0) begin
                txLowpowerSubstate <= TXS_NOT;
                rxLowpowerSubstate <= RXS_NOT;
            end else begin
                unique case (txLowpowerSubstate)
                    TXS_NOT: if (ctrl_reg[`PLS_CTRL_TX_L0S])
                        txLowpowerSubstate <= TXS_ENTRY;
                    TXS_ENTRY: txLowpowerSubstate <= TXS_IDLE;
                    TXS_IDLE: if (!ctrl_reg[`PLS_CTRL_TX_L0S])
                        txLowpowerSubstate <= TXS_FTS;
                    TXS_FTS: txLowpowerSubstate <= TXS_NOT;
                    default: txLowpowerSubstate <= TXS_NOT;
                endcase
                unique case (rxLowpowerSubstate)
                    RXS_NOT: if (partnerElecIdle)
                        rxLowpowerSubstate <= RXS_ENTRY;
                    RXS_ENTRY: rxLowpowerSubstate <= RXS_IDLE;
                    RXS_IDLE: if (!partnerElecIdle)
                        rxLowpowerSubstate <= RXS_FTS;
                    RXS_FTS: rxLowpowerSubstate <= RXS_NOT;
                endcase
            end
        end
    end

    // Transceiver controls. Below 5G, unless the faces-up bit is set, the link runs -3.5dB
    // regardless of source, since de-emphasis choice only matters at the faster rate.
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            xcvrDetectOrLoop <= 1'b0;
            xcvrPcsReset <= 1'b1;
            xcvrDeemphasisCtrl <= `PLS_DEEMPH_3P5DB;
            xcvrSwingMargin <= 3'h0;
            lanePowerState <= {LANES{`PLS_PWR_P1}};
        end else if (pipeEn_reg) begin
            xcvrPcsReset <= ctrl_reg[`PLS_CTRL_PCS_HOLD];
            xcvrSwingMargin <= margin_reg;
            xcvrDetectOrLoop <= (state_next == DET_ACTIVE);
            if (state_next == DET_QUIET || state_next == DET_ACTIVE) begin
                lanePowerState <= {LANES{`PLS_PWR_P1}};
            end else if (txLowpowerSubstate == TXS_IDLE) begin
                lanePowerState <= {LANES{`PLS_PWR_P0S}};
            end else begin
                lanePowerState <= {LANES{`PLS_PWR_P0}};
            end
            if (ctrl_reg[`PLS_CTRL_FACES_UP]) begin
                xcvrDeemphasisCtrl <= preferredDeemphasisIn;
            end else if (currentRateSel == `PLS_RATE_5G0) begin
                xcvrDeemphasisCtrl <= deemphasisSourceSel ?
                    ctrl_reg[`PLS_CTRL_SEL_DEEMPH] :
                    partnerDeemphasis;
            end else begin
                xcvrDeemphasisCtrl <= `PLS_DEEMPH_3P5DB;
            end
        end
    end

endmodule : pls_link_ctrl

// ### verif/pls_link_chk.sv
// Concurrent checks on the ports of the link status and control block.
// Assumes core_clk samples the pipe clock pin as the design does.
`timescale 1ns/1ns
`include "pls_defs.svh"
module pls_link_chk
    import pls_pkg::*;
#(
    parameter int LANES = 8
) (
    input wire logic core_clk,
    input wire logic resetn,
    input wire logic phySideClock,
    input wire logic [5:0] trainingStateCode,
    input wire logic phyUpLow_n,
    input wire logic currentRateSel,
    input wire logic [2:0] txLowpowerSubstate,
    input wire logic [2:0] firstTrainedWidth,
    input wire logic fastRateCapableFlag,
    input wire logic partnerFastRateFlag,
    input wire logic xcvrDetectOrLoop,
    input wire logic [2*LANES-1:0] lanePowerState
);
    logic pipeQ;
    logic [3:0] sinceRise;

    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!resetn);

    // Counts core cycles since a pipe rising edge was seen; saturates so that a
    // stalled pipe clock cannot wrap back into the legal window.
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            pipeQ <= 1'b0;
            sinceRise <= 4'hF;
        end else begin
            pipeQ <= phySideClock;
            if (phySideClock && !pipeQ) begin
                sinceRise <= 4'h0;
            end else if (sinceRise != 4'hF) begin
                sinceRise <= sinceRise + 4'h1;
            end
        end
    end

    chk_code_reserved: assert property (
        trainingStateCode < 6'h34)
        else $error("reserved training state code shown");
    chk_tx_reserved: assert property (
        txLowpowerSubstate[2] == 1'b0)
        else $error("reserved tx substate shown");
    chk_linkup_state: assert property (!phyUpLow_n |->
        trainingStateCode inside {`PLS_CODE_L0, `PLS_CODE_REC_LOCK,
        `PLS_CODE_REC_CFG, `PLS_CODE_REC_SPEED, `PLS_CODE_REC_IDLE})
        else $error("link up outside L0 or recovery");
    chk_fast_partner: assert property (fastRateCapableFlag |->
        partnerFastRateFlag) else $error("fast flag without partner");
    chk_rate_linkup: assert property (
        currentRateSel |-> !phyUpLow_n)
        else $error("fast rate while link down");
    chk_first_width: assert property (
        firstTrainedWidth != 3'h0 |=>
        firstTrainedWidth == $past(firstTrainedWidth) &&
        firstTrainedWidth <= 3'h4)
        else $error("first width changed or out of range");
    chk_lane_power: assert property (
        lanePowerState[1:0] != 2'h3 &&
        lanePowerState == {LANES{lanePowerState[1:0]}})
        else $error("lane power code reserved or unequal");
    chk_detect_power: assert property (xcvrDetectOrLoop |->
        lanePowerState[1:0] inside {`PLS_PWR_P1, `PLS_PWR_P0})
        else $error("detect asserted outside P1 or P0");
    chk_pipe_sync: assert property (
        $changed({trainingStateCode, phyUpLow_n, currentRateSel}) |->
        sinceRise inside {[4'h1:4'hA]})
        else $error("output moved away from a pipe edge");
endmodule : pls_link_chk

bind pls_link_ctrl pls_link_chk #(.LANES(LANES)) i_pls_link_chk (.*);

// ### verif/pls_xcvr_model.sv
// Behavioural transceiver and training partner for the link status block.
// Assumes the bench sets the partner's advertisement through cfg.
`timescale 1ns/1ns
module pls_xcvr_model #(
    parameter int DET_DELAY = 60
) (
    input wire logic core_clk,
    input wire logic resetn,
    input wire logic xcvrDetectOrLoop,
    input wire logic [7:0] cfg,
    output logic phySideClock,
    output logic [2:0] laneRxStatusCode,
    output logic partnerTrainingSeen,
    output logic [1:0] partnerWidth,
    output logic partnerLaneFlip,
    output logic partnerUpconfigBit,
    output logic partnerFastRate,
    output logic partnerDeemphasis,
    output logic partnerElecIdle
);
    int detCnt;
    logic found;

    // The pipe clock runs free, unrelated in phase to the core clock.
    initial begin
        phySideClock = 1'b0;
        #7;
        forever #80 phySideClock = ~phySideClock;
    end

    // Detection answers only after a delay and only while still requested.
    always @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            detCnt <= 0;
            found <= 1'b0;
            laneRxStatusCode <= 3'h0;
        end else begin
            if (xcvrDetectOrLoop && detCnt < DET_DELAY) detCnt <= detCnt + 1;
            found <= found | (detCnt == DET_DELAY);
            laneRxStatusCode <= (xcvrDetectOrLoop && detCnt == DET_DELAY) ?
                3'h3 : 3'h0;
        end
    end

    assign partnerTrainingSeen = cfg[0] & found;
    assign partnerWidth = cfg[2:1];
    assign partnerLaneFlip = cfg[3];
    assign partnerUpconfigBit = cfg[4];
    assign partnerFastRate = cfg[5];
    assign partnerDeemphasis = cfg[6];
    assign partnerElecIdle = cfg[7];
endmodule : pls_xcvr_model

// ### verif/testbench.sv
// Self-checking bench for the link status and control block.
// Assumes the partner model supplies the pipe clock and training inputs.
`timescale 1ns/1ns
`include "pls_defs.svh"
module testbench import pls_pkg::*;;
    logic core_clk = 1'b0;
    logic resetn = 1'b0;
    logic [7:0] regAddr = 8'h00;
    logic [31:0] regWrData = 32'h0, regRdData, rdv;
    logic regWrStb = 1'b0, regRdStb = 1'b0, phySideClock;
    logic [1:0] forcedChangeReq = 2'h0, forcedTargetWidth = 2'h0;
    logic forcedTargetSpeed = 1'b0, forcedChangeAutonomous = 1'b0;
    logic preferredDeemphasisIn = 1'b0, deemphasisSourceSel = 1'b0;
    logic [7:0] pcfg = 8'h00;
    logic [2:0] laneRxStatusCode, txLowpowerSubstate, firstTrainedWidth;
    logic [2:0] xcvrSwingMargin;
    logic [1:0] partnerWidth, currentWidthSel, laneOrderFlipMode;
    logic [1:0] rxLowpowerSubstate;
    logic partnerTrainingSeen, partnerLaneFlip, partnerUpconfigBit;
    logic partnerFastRate, partnerDeemphasis, partnerElecIdle;
    logic currentRateSel, phyUpLow_n, upconfigCapableFlag, xcvrRateCtrl;
    logic fastRateCapableFlag, partnerFastRateFlag, xcvrDetectOrLoop;
    logic xcvrPcsReset, xcvrDeemphasisCtrl;
    logic [5:0] trainingStateCode;
    logic [15:0] lanePowerState;
    int nMismatch = 0;
    int checked = 0;

    always #2 core_clk = ~core_clk;

    // Every bench signal but pcfg carries the name of the port that it meets.
    pls_link_ctrl #(.LANES(8), .DET_WAIT(16'h0008)) i_pls_link_ctrl (.*);

    pls_xcvr_model i_pls_xcvr_model (.cfg(pcfg), .*);

    task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            nMismatch++;
            $display("BAD %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk

    task wr(input logic [7:0] a, input logic [31:0] d);
        regAddr <= a;
        regWrData <= d;
        regWrStb <= 1'b1;
        @(posedge core_clk);
        regWrStb <= 1'b0;
        @(posedge core_clk);
    endtask : wr

    // Read data stand only in the cycle after the strobe.
    task rd(input logic [7:0] a, output logic [31:0] d);
        regAddr <= a;
        regRdStb <= 1'b1;
        @(posedge core_clk);
        regRdStb <= 1'b0;
        #1;
        d = regRdData;
        @(posedge core_clk);
    endtask : rd

    task wait_for(input int which, input logic [5:0] v);
        int i;
        logic [5:0] cur;
        for (i = 0; i < 6000; i++) begin
            cur = (which == 0) ? trainingStateCode : (which == 1) ?
                {3'h0, txLowpowerSubstate} : {4'h0, rxLowpowerSubstate};
            if (cur === v) break;
            @(posedge core_clk);
        end
        checked++;
        if (i == 6000) begin
            nMismatch++;
            $display("BAD wait%0d expected %h seen %h", which, v, cur);
        end
    endtask : wait_for

    // Outputs follow a pipe edge by a few core cycles of sampling.
    task wait_pipe(input int n);
        repeat (n) @(posedge phySideClock);
        repeat (8) @(posedge core_clk);
    endtask : wait_pipe

    task final_report;
        $display("checked %0d nMismatch %0d", checked, nMismatch);
        if (nMismatch == 0 && checked > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : final_report

    initial begin
        #200000;
        nMismatch++;
        final_report();
    end

    initial begin
        repeat (16) @(posedge core_clk);
        resetn <= 1'b1;
        @(posedge core_clk);
        chk("firstWidth", firstTrainedWidth, 3'h0);
        chk("upLow", phyUpLow_n, 1'b1);
        chk("rate", currentRateSel, 1'b0);
        chk("pcsReset", xcvrPcsReset, 1'b1);
        chk("power", lanePowerState, {8{`PLS_PWR_P1}});
        chk("code", trainingStateCode, `PLS_CODE_DET_QUIET);
        rd(`PLS_ADDR_CTRL, rdv);
        chk("ctrl", rdv, `PLS_CTRL_RESET);
        wr(8'h10, 32'hFFFF_FFFF);
        rd(8'h10, rdv);
        chk("unmapped", rdv, 32'h0);
        wr(`PLS_ADDR_MARGIN, 32'h5);
        wait_pipe(3);
        chk("margin", xcvrSwingMargin, 3'h5);
        pcfg <= 8'h3D;
        wr(`PLS_ADDR_CTRL, 32'h0D);
        wait_for(0, `PLS_CODE_DET_ACTIVE);
        chk("detect", xcvrDetectOrLoop, 1'b1);
        chk("pcsRun", xcvrPcsReset, 1'b0);
        wait_for(0, `PLS_CODE_POL_ACTIVE);
        wait_for(0, `PLS_CODE_CFG_LWIDTH);
        wait_for(0, `PLS_CODE_CFG_COMPLETE);
        wait_for(0, `PLS_CODE_CFG_IDLE);
        wait_for(0, `PLS_CODE_L0);
        chk("upLow", phyUpLow_n, 1'b0);
        chk("width", currentWidthSel, 2'h2);
        chk("flip", laneOrderFlipMode, 2'h2);
        chk("firstWidth", firstTrainedWidth, 3'h3);
        chk("upcfg", upconfigCapableFlag, 1'b1);
        chk("fastCap", fastRateCapableFlag, 1'b1);
        chk("partnerFast", partnerFastRateFlag, 1'b1);
        chk("rateCtrl", xcvrRateCtrl, 1'b0);
        rd(`PLS_ADDR_STATUS, rdv);
        chk("status", rdv, 32'hA960);
        forcedTargetSpeed <= 1'b1;
        forcedChangeAutonomous <= 1'b1;
        forcedChangeReq <= 2'h2;
        wait_for(0, `PLS_CODE_REC_SPEED);
        wait_for(0, `PLS_CODE_L0);
        forcedChangeReq <= 2'h0;
        wait_pipe(2);
        chk("rate", currentRateSel, 1'b1);
        chk("rateCtrl", xcvrRateCtrl, 1'b1);
        chk("width", currentWidthSel, 2'h2);
        chk("deemph", xcvrDeemphasisCtrl, `PLS_DEEMPH_6DB);
        rd(`PLS_ADDR_CAPS, rdv);
        chk("caps", rdv, 32'hF3);
        deemphasisSourceSel <= 1'b1;
        wr(`PLS_ADDR_CTRL, 32'h2D);
        wait_pipe(3);
        chk("deemph", xcvrDeemphasisCtrl, `PLS_DEEMPH_3P5DB);
        forcedTargetSpeed <= 1'b0;
        forcedTargetWidth <= 2'h1;
        forcedChangeReq <= 2'h1;
        wait_for(0, `PLS_CODE_REC_IDLE);
        wait_for(0, `PLS_CODE_L0);
        forcedChangeReq <= 2'h0;
        wait_pipe(2);
        chk("width", currentWidthSel, 2'h1);
        chk("rate", currentRateSel, 1'b1);
        pcfg <= 8'hBD;
        wr(`PLS_ADDR_CTRL, 32'h6D);
        wait_for(1, 6'h2);
        wait_for(2, 6'h2);
        // Lane power follows the tx substate one pipe cycle later.
        wait_pipe(1);
        chk("power", lanePowerState, {8{`PLS_PWR_P0S}});
        pcfg <= 8'h3D;
        wr(`PLS_ADDR_CTRL, 32'h2D);
        wait_for(1, 6'h3);
        wait_for(1, 6'h0);
        preferredDeemphasisIn <= 1'b0;
        wr(`PLS_ADDR_CTRL, 32'h3D);
        wait_pipe(2);
        chk("deemphUp", xcvrDeemphasisCtrl, `PLS_DEEMPH_6DB);
        wr(`PLS_ADDR_CTRL, 32'h2C);
        wait_for(0, `PLS_CODE_DET_QUIET);
        wait_pipe(1);
        chk("upLow", phyUpLow_n, 1'b1);
        chk("rate", currentRateSel, 1'b0);
        chk("firstWidth", firstTrainedWidth, 3'h3);
        final_report();
    end
endmodule : testbench
